/* File: wrap_timer_defines.svh */
// Notes on behaviour
// R1: Eight-bit up-counter, free-running or modulo
// R2: Fixed-rate clock is reference divided by two
// R3: Keeps counting in wait; irq can wake
// R4: Stop mode halts counting unconditionally
// R5: Reset restores defaults; interrupt exit resumes
// R6: Debug mode suspends counting; resumes held value
// R7: External pin synchronised; at most quarter bus
// R8: Overflow flag bit 7 sets on wrap
// R9: Flag clears by read-then-write-zero sequence
// R10: Counter clear or limit write clears flag
// R11: Enabled flag drives interrupt; reset clears enable
// R12: Software clears flag before setting enable
// R13: Bit 5 write-one clears counter, reads zero
// R14: Halt bit 4 holds count; reset sets
// R15: Source field 5:4 selects four clocks
// R16: Source change keeps present count
// R17: Prescale 3:0 divides by power of two
// R18: Prescale change keeps present count
// R19: Reset clears source and prescale fields
// R20: Count register read-only, resets zero
// R21: Increment to limit, wrap to zero
// R22: Limit write clears counter and flag
// R23: Overflow mid-sequence abandons the flag clear
// R24: Two-stage sync then edge detect pin; code syncs through three stages, second and third must agree
`ifndef WRAP_TIMER_DEFINES_SVH
`define WRAP_TIMER_DEFINES_SVH
`define ADDR_STATUS_CONTROL 4'h0
`define ADDR_CLOCK_CONFIG 4'h4
`define ADDR_CURRENT_COUNT 4'h8
`define ADDR_WRAP_LIMIT 4'hc
`define BIT_OVERFLOW 7
`define BIT_IRQ_ENABLE 6
`define BIT_COUNT_CLEAR 5
`define BIT_COUNT_HALT 4
`define SRC_HI 5
`define SRC_LO 4
`define PS_HI 3
`define PS_LO 0
`define PS_MAX 4'h8
`define RESET_BYTE 8'h00
`define RESET_CONTROL 8'h10
`endif

/* File: wrap_timer_pkg.sv */
package wrap_timer_pkg;
  typedef enum logic [1:0] {SRC_BUS, SRC_FIXED, SRC_PIN_FALL, SRC_PIN_RISE} clock_source_t;
  typedef struct packed {
    logic [3:0] adr;
    logic we;
    logic sel;
    logic [7:0] dat;
  } bus_req_t;
endpackage

/* File: wrap_prescaler.sv */
`timescale 1ns/1ns
`include "wrap_timer_defines.svh"
module wrap_prescaler
  import wrap_timer_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_tick,
  input wire logic i_clear,
  input wire logic [3:0] i_prescale_select,
  output logic o_tick
);
  // Taps and saturation assume an eight-stage divider
  if (WIDTH != 8)
  begin : g_bad_width
    $error("prescaler width must be 8");
  end

  logic [WIDTH-1:0] div_q;
  logic [WIDTH-1:0] div_d;
  logic [WIDTH:0] full_count;
  logic [3:0] ps_eff;
  logic [WIDTH-1:0] mask;
  logic tap_hit;

  // Codes above eight divide by 256
  assign ps_eff = (i_prescale_select > `PS_MAX) ? `PS_MAX : i_prescale_select; // R17
  assign full_count = ({{WIDTH{1'b0}}, 1'b1} << ps_eff) - {{WIDTH{1'b0}}, 1'b1};
  assign mask = full_count[WIDTH-1:0];
  // Divider not reset on change, so a prescale change never clears the count
  assign tap_hit = ((div_q & mask) == mask); // R18
  assign div_d = i_clear ? '0 : (i_tick ? div_q + {{(WIDTH-1){1'b0}}, 1'b1} : div_q);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      div_q <= '0;
    else
      div_q <= div_d;
  end

  assign o_tick = i_tick && tap_hit;
endmodule // wrap_prescaler

/* File: wrap_timer.sv */
`timescale 1ns/1ns
`include "wrap_timer_defines.svh"
module wrap_timer
  import wrap_timer_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [0:0] i_wb_sel,
  input wire logic [7:0] i_wb_dat,
  output logic [7:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_ref_fixed_clock,
  input wire logic i_ext_count_clock_pin,
  input wire logic i_stop_mode,
  input wire logic i_debug_active,
  output logic o_irq
);
  bus_req_t req;
  logic ack_q;
  logic [7:0] rdat_q;
  logic [7:0] rdat_d;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [7:0] limit_q;
  logic [5:0] clk_cfg_q;
  logic flag_q;
  logic flag_d;
  logic irq_en_q;
  logic halt_q;
  logic armed_q;
  logic armed_d;
  logic irq_q;
  logic [2:0] pin_sync_q;
  logic pin_level_q;
  logic fixed_div_q;
  logic [2:0] ref_sync_q;
  logic ref_level_q;

  assign req = '{adr: i_wb_adr, we: i_wb_we, sel: i_wb_sel[0], dat: i_wb_dat};

  wire access = i_wb_cyc && i_wb_stb && !ack_q;
  wire wr_en = access && req.we && req.sel;
  wire rd_en = access && !req.we;
  wire hit_sc = req.adr == `ADDR_STATUS_CONTROL;
  wire hit_clk = req.adr == `ADDR_CLOCK_CONFIG;
  wire hit_cnt = req.adr == `ADDR_CURRENT_COUNT;
  wire hit_lim = req.adr == `ADDR_WRAP_LIMIT;
  wire wr_sc = wr_en && hit_sc;
  wire wr_lim = wr_en && hit_lim; // R22
  wire do_clear = (wr_sc && req.dat[`BIT_COUNT_CLEAR]) || wr_lim; // R10 R13
  wire [7:0] sc_view = {flag_q, irq_en_q, 1'b0, halt_q, 4'h0}; // R13

  assign rdat_d = hit_sc ? sc_view :
                  hit_clk ? {2'b00, clk_cfg_q} :
                  hit_cnt ? count_q : // R20
                  hit_lim ? limit_q : `RESET_BYTE;

  // Pin: three stages; second and third must agree before a change counts
  wire pin_stable = pin_sync_q[1] == pin_sync_q[2]; // R24 R7
  wire pin_next = pin_stable ? pin_sync_q[2] : pin_level_q;
  wire pin_rise = pin_next && !pin_level_q;
  wire pin_fall = !pin_next && pin_level_q;
  // Reference clock is slow; its divide-by-two toggles on each rising edge
  wire ref_stable = ref_sync_q[1] == ref_sync_q[2];
  wire ref_next = ref_stable ? ref_sync_q[2] : ref_level_q;
  wire ref_rise = ref_next && !ref_level_q;
  wire fixed_tick = ref_rise && fixed_div_q; // R2

  wire [1:0] src_code = clk_cfg_q[`SRC_HI:`SRC_LO];
  clock_source_t src;
  assign src = clock_source_t'(src_code); // R15 R16
  wire src_tick = (src == SRC_BUS) ? 1'b1 :
                  (src == SRC_FIXED) ? fixed_tick :
                  (src == SRC_PIN_FALL) ? pin_fall : pin_rise;
  // Wait mode is not an input: counting goes on regardless
  wire running = !halt_q && !i_stop_mode && !i_debug_active; // R3 R4 R6 R14
  logic count_tick;

  wrap_prescaler #(.WIDTH(8)) u_prescaler (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_tick(src_tick && running),
    .i_clear(do_clear),
    .i_prescale_select(clk_cfg_q[`PS_HI:`PS_LO]),
    .o_tick(count_tick)
  );

  wire at_limit = (limit_q != `RESET_BYTE) && (count_q == limit_q); // R1 R21
  wire overflow = count_tick && (at_limit || (count_q == 8'hff)); // R8

  assign count_d = do_clear ? `RESET_BYTE :
                   count_tick ? (at_limit ? `RESET_BYTE : count_q + 8'h01) : count_q; // R21

  // Read of set flag arms; later overflow disarms, so the zero write is ignored
  assign armed_d = overflow ? 1'b0 : // R23
                   (rd_en && hit_sc && flag_q) ? 1'b1 :
                   (wr_sc ? 1'b0 : armed_q); // R9
  assign flag_d = overflow ? 1'b1 : // R8
                  do_clear ? 1'b0 : // R10
                  (wr_sc && armed_q && !req.dat[`BIT_OVERFLOW]) ? 1'b0 : flag_q; // R9

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      pin_sync_q <= 3'h0;
      ref_sync_q <= 3'h0;
    end
    else
    begin
      pin_sync_q <= {pin_sync_q[1:0], i_ext_count_clock_pin};
      ref_sync_q <= {ref_sync_q[1:0], i_ref_fixed_clock};
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset) // R5 R19
    begin
      pin_level_q <= 1'b0;
      ref_level_q <= 1'b0;
      fixed_div_q <= 1'b0;
      count_q <= `RESET_BYTE;
      limit_q <= `RESET_BYTE;
      clk_cfg_q <= 6'h00;
      flag_q <= 1'b0;
      irq_en_q <= 1'b0;
      halt_q <= 1'b1;
      armed_q <= 1'b0;
      irq_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= `RESET_BYTE;
    end
    else
    begin
      pin_level_q <= pin_next;
      ref_level_q <= ref_next;
      fixed_div_q <= fixed_div_q ^ ref_rise;
      count_q <= count_d;
      flag_q <= flag_d;
      armed_q <= armed_d;
      irq_q <= flag_d && (wr_sc ? req.dat[`BIT_IRQ_ENABLE] : irq_en_q); // R11 R3
      ack_q <= access;
      if (rd_en)
        rdat_q <= rdat_d;
      if (wr_lim)
        limit_q <= req.dat;
      if (wr_en && hit_clk)
        clk_cfg_q <= req.dat[5:0];
      if (wr_sc)
      begin
        irq_en_q <= req.dat[`BIT_IRQ_ENABLE]; // R11
        halt_q <= req.dat[`BIT_COUNT_HALT];
      end
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;
  assign o_irq = irq_q;

  a_ack_one_cycle: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_wb_ack |=> !o_wb_ack) else $error("ack held too long");
  a_halt_holds: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R14
    halt_q && !do_clear |=> $stable(count_q)) else $error("count moved while halted");
  a_stop_holds: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R4
    i_stop_mode && !do_clear |=> $stable(count_q)) else $error("count moved in stop");
  a_debug_holds: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R6
    i_debug_active && !do_clear |=> $stable(count_q)) else $error("count moved in debug");
  a_clear_zero: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R13
    do_clear |=> count_q == 8'h00 && (!flag_q || $past(overflow))) else $error("clear failed");
  a_wrap_sets_flag: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R8
    overflow && !do_clear |=> flag_q && count_q == 8'h00) else $error("wrap missed flag");
  a_limit_bound: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R21
    limit_q != 8'h00 && count_q <= limit_q && !wr_lim |=> count_q <= limit_q) else $error("count passed limit");
  a_irq_follows: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R11
    flag_q && irq_en_q |-> o_irq) else $error("irq missing");
  a_bus_run: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R15
    src == SRC_BUS && running && clk_cfg_q[3:0] == 4'h0 && !do_clear && !at_limit && count_q != 8'hff
    |=> count_q == $past(count_q) + 8'h01) else $error("bus clock count stalled");
  a_abandon_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R23
    overflow ##1 (wr_sc && !req.dat[`BIT_COUNT_CLEAR]) |=> flag_q) else $error("flag lost");
  c_wrap: cover property (@(posedge i_sys_clk) overflow && limit_q != 8'h00);
  c_flag_clear: cover property (@(posedge i_sys_clk) flag_q ##1 !flag_q);
  c_pin_rise: cover property (@(posedge i_sys_clk) src == SRC_PIN_RISE && pin_rise && running);
endmodule // wrap_timer

/* File: testbench.sv */
`timescale 1ns/1ns
`include "wrap_timer_defines.svh"
module testbench
  import wrap_timer_pkg::*;
;
  localparam logic [3:0] SC = `ADDR_STATUS_CONTROL;
  localparam logic [3:0] CC = `ADDR_CLOCK_CONFIG;
  localparam logic [3:0] CN = `ADDR_CURRENT_COUNT;
  localparam logic [3:0] LM = `ADDR_WRAP_LIMIT;
  logic sys_clk, reset, act, ref_clk, pin, stop_mode, dbg, ack, irq;
  bus_req_t req;
  logic [7:0] o_dat, rdat, c;
  int bad_count, cmp_count, n;
  wrap_timer uut (.i_sys_clk(sys_clk), .i_reset(reset), .i_wb_cyc(act), .i_wb_stb(act), .i_wb_we(req.we),
    .i_wb_adr(req.adr), .i_wb_sel(req.sel), .i_wb_dat(req.dat), .o_wb_dat(o_dat), .o_wb_ack(ack),
    .i_ref_fixed_clock(ref_clk), .i_ext_count_clock_pin(pin), .i_stop_mode(stop_mode),
    .i_debug_active(dbg), .o_irq(irq));
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // One request held until ack is sampled high; read data taken at that edge
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
    int k;
    @(posedge sys_clk);
    act <= 1'b1;
    req <= '{a, w, 1'b1, d};
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    rdat = o_dat;
    act <= 1'b0;
    if (k >= 20)
    begin
      bad_count++;
      conclude();
    end
  endtask
  task automatic t_reset;
    bus(SC, 0, 0); check(rdat, 8'h10);
    bus(CC, 0, 0); check(rdat, 8'h00);
    bus(CN, 0, 0); check(rdat, 8'h00);
    bus(LM, 0, 0); check(rdat, 8'h00);
    bus(4'h2, 0, 0); check(rdat, 8'h00);
    check({7'h0, irq}, 8'h00);
  endtask
  task automatic t_modulo;
    bus(CN, 1, 8'h55); bus(CN, 0, 0); check(rdat, 8'h00);
    bus(LM, 1, 8'h03); bus(SC, 1, 8'h00); idle(10);
    bus(CN, 0, 0); check({7'h0, rdat <= 8'h03}, 8'h01);
    bus(SC, 0, 0); check(rdat, 8'h80);
    // Gap longer than one wrap period forces a second overflow
    // Halting in the zero write keeps a wrongly cleared flag from setting again
    idle(6); bus(SC, 1, 8'h10); bus(SC, 0, 0); check(rdat, 8'h90);
    bus(SC, 1, 8'h10); bus(SC, 0, 0); bus(SC, 1, 8'h10); bus(CN, 0, 0); c = rdat;
    bus(SC, 0, 0); check(rdat, 8'h10);
    idle(5); bus(CN, 0, 0); check(rdat, c);
  endtask
  task automatic t_trst_irq;
    bus(SC, 1, 8'h70); bus(CN, 0, 0); check(rdat, 8'h00);
    bus(SC, 0, 0); check(rdat, 8'h50);
    bus(SC, 1, 8'h40);
    for (n = 0; n < 20 && irq !== 1'b1; n++) @(posedge sys_clk);
    check({7'h0, irq}, 8'h01);
    bus(SC, 1, 8'h10); bus(LM, 1, 8'h03); bus(SC, 0, 0); check(rdat, 8'h10);
    bus(CN, 0, 0); check(rdat, 8'h00);
    bus(SC, 1, 8'h50);
    idle(2); check({7'h0, irq}, 8'h00);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 2; m++)
    begin
      bus(SC, 1, 8'h00);
      {stop_mode, dbg} <= (m == 0) ? 2'b10 : 2'b01;
      idle(2); bus(CN, 0, 0); c = rdat;
      idle(5); bus(CN, 0, 0); check(rdat, c);
      {stop_mode, dbg} <= 2'b00;
    end
  endtask
  task automatic t_prescale;
    bus(SC, 1, 8'h30); bus(LM, 1, 8'h00); bus(CC, 1, 8'h02); bus(SC, 1, 8'h00);
    idle(40); bus(SC, 1, 8'h10); bus(CN, 0, 0);
    check({7'h0, rdat >= 8'h09 && rdat <= 8'h0b}, 8'h01);
    c = rdat;
    // Codes above eight must saturate at the slowest divide
    bus(CC, 1, 8'h0f); bus(SC, 1, 8'h00); idle(100); bus(CN, 0, 0);
    check({7'h0, rdat >= c && rdat <= c + 8'h01}, 8'h01);
  endtask
  task automatic t_sources;
    for (int s = 1; s < 4; s++)
    begin
      bus(SC, 1, 8'h30); bus(CC, 1, {2'b00, s[1:0], 4'h0}); bus(SC, 1, 8'h20);
      repeat (8)
      begin
        {ref_clk, pin} <= 2'b11;
        idle(8);
        {ref_clk, pin} <= 2'b00;
        idle(8);
      end
      idle(8); bus(SC, 1, 8'h10); bus(CN, 0, 0);
      check({7'h0, (s == 1) ? (rdat >= 8'h03 && rdat <= 8'h04) : (rdat == 8'h08)}, 8'h01);
    end
  endtask
  initial
  begin
    reset = 1'b1;
    act = 1'b0;
    req = '0;
    {ref_clk, pin, stop_mode, dbg} = 4'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_modulo();
    t_trst_irq();
    t_modes();
    t_prescale();
    t_sources();
    conclude();
  end
endmodule // testbench
